// >>> hdl/cstd_pkg.sv
package cstd_pkg;

  // register offsets
  localparam logic [15:0] CSTD_SUPPLY_TIMING_OFS = 16'hfe04;
  localparam logic [15:0] CSTD_DETECT_CTRL_OFS   = 16'hfe05;
  localparam logic [15:0] CSTD_SUPPLY_CTRL_OFS   = 16'hfe03;

  // reset values
  localparam logic [7:0] CSTD_SUPPLY_TIMING_RST = 8'h0f;
  localparam logic [7:0] CSTD_DETECT_CTRL_RST   = 8'h00;

  // supply timing field positions
  localparam int CSTD_SETTLE_LSB   = 0;
  localparam int CSTD_POWEROFF_LSB = 4;

  // detect control bit positions
  localparam int CSTD_FILTER_BIT  = 7;
  localparam int CSTD_DETON_BIT   = 6;
  localparam int CSTD_SENSE_BIT   = 3;
  localparam int CSTD_PULLUPN_BIT = 2;
  localparam int CSTD_PULLDN_BIT  = 1;
  localparam int CSTD_PRESENT_BIT = 0;

  // supply control bit positions
  localparam int CSTD_LEVEL_LSB   = 6;
  localparam int CSTD_WAITRDY_BIT = 4;
  localparam int CSTD_GOOD_BIT    = 3;
  localparam int CSTD_POWER_DOWN_BIT   = 0;

  // timing: slow clock period, debounce window in 1 kHz ticks
  localparam real CSTD_SLOW_PERIOD_US = 30.5;
  localparam int  CSTD_FILTER_MS      = 64;
  localparam int  CSTD_FILTER_TICKS   = CSTD_FILTER_MS;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cstd_bus_req_t;

  typedef enum logic [1:0] {
    CSTD_LVL_OFF,
    CSTD_LVL_1V8,
    CSTD_LVL_3V0,
    CSTD_LVL_5V0
  } cstd_level_t;

endpackage

// >>> hdl/cstd_supervisor.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// Operation
// - settle interval starts at activation; supply good checked only at its end
// - supply bad at timeout: card event, deactivate, clear level select
// - settle time is settle field times one 32768 Hz period
// - settle field zero: no timeout; activate on wait-for-ready and supply good
// - emergency deactivations skip the power-off delay
// - power-off field zero adds no delay
// - card detection works without the card logic clock
// - power-down bypasses debounce, presence still reported
// - debounce needs 64 ticks of 1 kHz stable assertion
// - present flag clears at once on detect deassertion
// - detect input active only when detect enable set; enable resets zero
// - sense bit one: high means present, else low means present
// - pull-up enable active low, pull-down active high, from register bits
// - present flag read-only; each change is a card event
// - nonzero level select starts activation; 01 1.8 V, 10 3.0 V, 11 5 V
// - card event or supply good falling starts deactivation; code acts on it only in SEQ_ON or SEQ_OFFDELAY
// - wait-for-ready set: activation waits for supply good; code uses it only with settle field zero
module cstd_supervisor
  import cstd_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // register port
  input  wire logic [15:0]   reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  // slow clocks
  input  wire logic          slow_clk_32k,
  input  wire logic          keypad_tick_1k,
  // card slot pins
  input  wire logic          card_detect_pin,
  input  wire logic          supply_good_flag,
  output logic               pullup_on_n,
  output logic               pulldown_on,
  // supply sequencing
  output logic [1:0]         supply_level_select,
  output logic               supply_active,
  output logic               deactivate,
  output logic               card_event
);

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic slow_s;
  logic kp_s;
  logic det_s;
  logic good_s;

  cstd_sync u_sync_slow (.core_clk(core_clk), .reset_n(reset_n),
                         .async_in(slow_clk_32k), .sync_out(slow_s));
  cstd_sync u_sync_kp   (.core_clk(core_clk), .reset_n(reset_n),
                         .async_in(keypad_tick_1k), .sync_out(kp_s));
  cstd_sync u_sync_det  (.core_clk(core_clk), .reset_n(reset_n),
                         .async_in(card_detect_pin), .sync_out(det_s));
  cstd_sync u_sync_good (.core_clk(core_clk), .reset_n(reset_n),
                         .async_in(supply_good_flag), .sync_out(good_s));

  logic slow_q;
  logic kp_q;
  logic good_q;
  logic slow_tick;
  logic kp_tick;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slow_q <= 1'b0;
      kp_q   <= 1'b0;
      good_q <= 1'b0;
    end
    else
    begin
      slow_q <= slow_s;
      kp_q   <= kp_s;
      good_q <= good_s;
    end
  end

  assign slow_tick = slow_s && !slow_q;
  assign kp_tick   = kp_s && !kp_q;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] timing_cfg;
  logic       filter_on;
  logic       detect_on;
  logic       detect_sense;
  logic [1:0] level;
  logic       wait_for_ready;
  logic       power_down;
  logic       card_present;
  logic       level_clear;
  logic       settle_fail;
  logic       wr_timing;
  logic       wr_detect;
  logic       wr_supply;

  assign wr_timing = reg_wr && (reg_addr == CSTD_SUPPLY_TIMING_OFS);
  assign wr_detect = reg_wr && (reg_addr == CSTD_DETECT_CTRL_OFS);
  assign wr_supply = reg_wr && (reg_addr == CSTD_SUPPLY_CTRL_OFS);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      timing_cfg <= CSTD_SUPPLY_TIMING_RST;
    else if (wr_timing)
      timing_cfg <= reg_wdata;
  end

  // present bit is never written; it is hardware state
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      filter_on    <= CSTD_DETECT_CTRL_RST[CSTD_FILTER_BIT];
      detect_on    <= CSTD_DETECT_CTRL_RST[CSTD_DETON_BIT];
      detect_sense <= CSTD_DETECT_CTRL_RST[CSTD_SENSE_BIT];
      pullup_on_n  <= CSTD_DETECT_CTRL_RST[CSTD_PULLUPN_BIT];
      pulldown_on  <= CSTD_DETECT_CTRL_RST[CSTD_PULLDN_BIT];
    end
    else if (wr_detect)
    begin
      filter_on    <= reg_wdata[CSTD_FILTER_BIT];
      detect_on    <= reg_wdata[CSTD_DETON_BIT];
      detect_sense <= reg_wdata[CSTD_SENSE_BIT];
      pullup_on_n  <= reg_wdata[CSTD_PULLUPN_BIT];
      pulldown_on  <= reg_wdata[CSTD_PULLDN_BIT];
    end
  end

  // hardware clear of level select wins over a same-cycle write
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      level          <= CSTD_LVL_OFF;
      wait_for_ready <= 1'b0;
      power_down     <= 1'b0;
    end
    else
    begin
      if (wr_supply)
      begin
        level          <= reg_wdata[CSTD_LEVEL_LSB +: 2];
        wait_for_ready <= reg_wdata[CSTD_WAITRDY_BIT];
        power_down     <= reg_wdata[CSTD_POWER_DOWN_BIT];
      end
      if (level_clear)
        level <= CSTD_LVL_OFF;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        CSTD_SUPPLY_TIMING_OFS: reg_rdata <= timing_cfg;
        CSTD_DETECT_CTRL_OFS:   reg_rdata <= {filter_on, detect_on, 2'b00, detect_sense,
                                              pullup_on_n, pulldown_on,
                                              card_present};
        CSTD_SUPPLY_CTRL_OFS:   reg_rdata <= {level, 1'b0, wait_for_ready, good_s,
                                              2'b00, power_down};
        default:                reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // card detect; runs on core_clk only, independent of the card logic clock

  logic       det_qual;
  logic [6:0] filt_cnt;
  logic       present_q;

  assign det_qual = detect_on && (det_s == detect_sense);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      filt_cnt     <= 7'h00;
      card_present <= 1'b0;
    end
    else if (!det_qual)
    begin
      filt_cnt     <= 7'h00;
      card_present <= 1'b0;
    end
    else if (!filter_on || power_down)
      card_present <= 1'b1;
    else if (!card_present && kp_tick)
    begin
      if (filt_cnt == 7'(CSTD_FILTER_TICKS - 1))
        card_present <= 1'b1;
      else
        filt_cnt <= filt_cnt + 7'h01;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      present_q  <= 1'b0;
      card_event <= 1'b0;
    end
    else
    begin
      present_q  <= card_present;
      card_event <= (present_q != card_present) || settle_fail;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // supply sequencing

  typedef enum logic [2:0] {SEQ_OFF, SEQ_WAITRDY, SEQ_SETTLE, SEQ_ON,
                            SEQ_OFFDELAY, SEQ_LOCKOUT} cstd_seq_t;
  cstd_seq_t  state;
  logic       settle_start;
  logic       settle_done;
  logic       off_start;
  logic       off_done;
  logic       emergency;
  logic [3:0] settle_val;
  logic [3:0] off_val;

  assign settle_val = timing_cfg[CSTD_SETTLE_LSB +: 4];
  assign off_val    = timing_cfg[CSTD_POWEROFF_LSB +: 4];
  assign emergency  = (present_q != card_present) || (good_q && !good_s);

  cstd_tick_counter #(.WIDTH(4)) u_settle (
    .core_clk(core_clk), .reset_n(reset_n), .start(settle_start),
    .abort(level == CSTD_LVL_OFF), .tick(slow_tick), .load(settle_val),
    .busy(), .done(settle_done));

  cstd_tick_counter #(.WIDTH(4)) u_off (
    .core_clk(core_clk), .reset_n(reset_n), .start(off_start),
    .abort(level != CSTD_LVL_OFF), .tick(slow_tick), .load(off_val),
    .busy(), .done(off_done));

  assign settle_start = (state == SEQ_OFF) && (level != CSTD_LVL_OFF)
                        && (settle_val != 4'h0);
  assign settle_fail  = (state == SEQ_SETTLE) && settle_done && !good_s;
  assign off_start    = (state == SEQ_ON) && (level == CSTD_LVL_OFF)
                        && (off_val != 4'h0);
  assign level_clear  = settle_fail;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= SEQ_OFF;
    else
    begin
      case (state)
        SEQ_OFF:
          if (level != CSTD_LVL_OFF)
            state <= (settle_val == 4'h0) ? SEQ_WAITRDY : SEQ_SETTLE;
        SEQ_WAITRDY:
          if (level == CSTD_LVL_OFF)
            state <= SEQ_OFF;
          else if (wait_for_ready && good_s)
            state <= SEQ_ON;
        SEQ_SETTLE:
          if (level == CSTD_LVL_OFF)
            state <= SEQ_OFF;
          else if (settle_fail)
            state <= SEQ_LOCKOUT;
          else if (settle_done)
            state <= SEQ_ON;
        SEQ_ON:
          if (emergency)
            state <= SEQ_LOCKOUT;
          else if (level == CSTD_LVL_OFF)
            state <= (off_val == 4'h0) ? SEQ_OFF : SEQ_OFFDELAY;
        SEQ_OFFDELAY:
          if (emergency || off_done)
            state <= SEQ_OFF;
          else if (level != CSTD_LVL_OFF)
            state <= SEQ_ON;
        SEQ_LOCKOUT:
          if (level == CSTD_LVL_OFF)
            state <= SEQ_OFF;
        default:
          state <= SEQ_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      supply_level_select <= 2'b00;
      supply_active       <= 1'b0;
      deactivate          <= 1'b0;
    end
    else
    begin
      supply_level_select <= level;
      supply_active       <= (state == SEQ_ON) || (state == SEQ_OFFDELAY);
      deactivate          <= (state == SEQ_OFF) || (state == SEQ_LOCKOUT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  clear_immediate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !det_qual |=> !card_present)
    else $error("present flag not cleared");

  detect_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !detect_on |=> !card_present)
    else $error("present flag set while detect off");

  bypass_fast_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (det_qual && power_down && $past(det_qual)) |=> card_present)
    else $error("bypass did not report presence");

  filter_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(card_present) && filter_on && !power_down |-> filt_cnt == 7'd63)
    else $error("present set before filter window");

  event_change_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (present_q != card_present) |=> card_event)
    else $error("change without card event");

  // the event pulse and the cleared level both appear on the edge after the failure
  fail_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    settle_fail |=> level == CSTD_LVL_OFF && card_event)
    else $error("settle failure handling wrong");

  pull_track_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_detect |=> pullup_on_n == $past(reg_wdata[CSTD_PULLUPN_BIT])
                  && pulldown_on == $past(reg_wdata[CSTD_PULLDN_BIT]))
    else $error("pull controls not updated");

  no_timeout_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == SEQ_WAITRDY && !wait_for_ready && level != CSTD_LVL_OFF)
    |=> state == SEQ_WAITRDY)
    else $error("activation without ready");

  zero_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == SEQ_ON && level == CSTD_LVL_OFF && off_val == 4'h0 && !emergency)
    |=> state == SEQ_OFF)
    else $error("power off delayed with zero field");

endmodule

// >>> hdl/cstd_sync.sv
`timescale 1ns/1ps
module cstd_sync
  import cstd_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // signal
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// >>> hdl/cstd_tick_counter.sv
`timescale 1ns/1ps
module cstd_tick_counter
  import cstd_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // control
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] load,
  // status
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] remain;

  // a zero-width counter cannot hold a load value
  if (WIDTH < 1)
    $error("counter width must be at least one");

  // counts down one per slow tick; done pulses when it reaches zero
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remain <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
        busy <= 1'b0;
      else if (start)
      begin
        remain <= load;
        busy   <= 1'b1;
      end
      else if (busy && tick)
      begin
        if (remain <= WIDTH'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        remain <= remain - WIDTH'(1);
      end
    end
  end

endmodule

// >>> sim/card_supply_timer_and_detect_test.sv
`timescale 1ns/1ps
module card_supply_timer_and_detect_test
  import cstd_pkg::*;
();
  localparam int SP    = 40;
  localparam int KP    = 16;
  localparam int LIMIT = 20000;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        slow_clk_32k, keypad_tick_1k, card_detect_pin, supply_good_flag;
  logic        pullup_on_n, pulldown_on, supply_active, deactivate, card_event;
  logic [1:0]  supply_level_select;
  logic        card_in = 1'b0;
  logic        sw_lvl = 1'b1;
  logic        supply_fail = 1'b0;
  logic [7:0]  rv;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          ev_cnt = 0;
  int          ev0;

  cstd_supervisor i_cstd_supervisor (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slow_clk_32k(slow_clk_32k),
    .keypad_tick_1k(keypad_tick_1k), .card_detect_pin(card_detect_pin),
    .supply_good_flag(supply_good_flag), .pullup_on_n(pullup_on_n),
    .pulldown_on(pulldown_on), .supply_level_select(supply_level_select),
    .supply_active(supply_active), .deactivate(deactivate), .card_event(card_event));

  cstd_slot_model i_cstd_slot_model (
    .core_clk(core_clk), .pullup_on_n(pullup_on_n), .pulldown_on(pulldown_on),
    .supply_level_select(supply_level_select), .card_detect_pin(card_detect_pin),
    .supply_good_flag(supply_good_flag), .slow_clk_32k(slow_clk_32k),
    .keypad_tick_1k(keypad_tick_1k), .card_in(card_in), .sw_lvl(sw_lvl),
    .supply_fail(supply_fail), .supply_active(supply_active));

  always #4 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (card_event === 1'b1)
      ev_cnt <= ev_cnt + 1;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
    chk(rv, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rchk(CSTD_SUPPLY_TIMING_OFS, 8'h0f);
    rchk(CSTD_DETECT_CTRL_OFS, 8'h00);
    rchk(16'hfe10, 8'h00);
    // unfiltered, sense high, pull-down; config lands before enable
    wr(CSTD_DETECT_CTRL_OFS, 8'h0b);
    wr(CSTD_DETECT_CTRL_OFS, 8'h4b);
    chk({7'h00, pulldown_on}, 8'h01);
    chk({7'h00, pullup_on_n}, 8'h00);
    rchk(CSTD_DETECT_CTRL_OFS, 8'h4a);
    ev0 = ev_cnt;
    card_in <= 1'b1;
    ticks(8);
    rchk(CSTD_DETECT_CTRL_OFS, 8'h4b);
    chk(8'(ev_cnt - ev0), 8'h01);
    wr(CSTD_DETECT_CTRL_OFS, 8'h0a);
    ticks(6);
    rchk(CSTD_DETECT_CTRL_OFS, 8'h0a);
    card_in <= 1'b0;
    sw_lvl <= 1'b0;
    wr(CSTD_DETECT_CTRL_OFS, 8'h00);
    wr(CSTD_DETECT_CTRL_OFS, 8'h40);
    ticks(6);
    rchk(CSTD_DETECT_CTRL_OFS, 8'h40);
    card_in <= 1'b1;
    ticks(6);
    rchk(CSTD_DETECT_CTRL_OFS, 8'h41);
    card_in <= 1'b0;
    sw_lvl <= 1'b1;
    wr(CSTD_DETECT_CTRL_OFS, 8'h04);
    ticks(1);
    chk({7'h00, pullup_on_n}, 8'h01);
    // debounce: an early drop must restart the 64-tick window
    wr(CSTD_DETECT_CTRL_OFS, 8'h8a);
    wr(CSTD_DETECT_CTRL_OFS, 8'hca);
    card_in <= 1'b1;
    ticks(30 * KP);
    card_in <= 1'b0;
    ticks(3 * KP);
    card_in <= 1'b1;
    ticks(58 * KP);
    rchk(CSTD_DETECT_CTRL_OFS, 8'hca);
    ticks(10 * KP);
    rchk(CSTD_DETECT_CTRL_OFS, 8'hcb);
    card_in <= 1'b0;
    ticks(4);
    rchk(CSTD_DETECT_CTRL_OFS, 8'hca);
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h01);
    card_in <= 1'b1;
    ticks(6);
    rchk(CSTD_DETECT_CTRL_OFS, 8'hcb);
    card_in <= 1'b0;
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h00);
    wr(CSTD_DETECT_CTRL_OFS, 8'h00);
    ticks(6);
    // every nonzero level code, each switched off with no power-off delay
    wr(CSTD_SUPPLY_TIMING_OFS, 8'h02);
    for (int lv = 1; lv < 4; lv++)
    begin
      wr(CSTD_SUPPLY_CTRL_OFS, 8'(lv << CSTD_LEVEL_LSB));
      ticks(5 * SP);
      chk({6'h00, supply_level_select}, 8'(lv));
      chk({7'h00, supply_active}, 8'h01);
      wr(CSTD_SUPPLY_CTRL_OFS, 8'h00);
      ticks(8);
      chk({7'h00, supply_active}, 8'h00);
    end
    // settle timeout with the supply never good
    supply_fail <= 1'b1;
    ev0 = ev_cnt;
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h80);
    ticks(30);
    chk({6'h00, supply_level_select}, 8'h02);
    ticks(3 * SP);
    chk({6'h00, supply_level_select}, 8'h00);
    chk(8'(ev_cnt - ev0), 8'h01);
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h00);
    // settle field zero: no timeout, wait for ready
    wr(CSTD_SUPPLY_TIMING_OFS, 8'h00);
    ev0 = ev_cnt;
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h50);
    ticks(10 * SP);
    chk({6'h00, supply_level_select}, 8'h01);
    chk(8'(ev_cnt - ev0), 8'h00);
    // supply good but wait-for-ready off: still no activation
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h40);
    supply_fail <= 1'b0;
    ticks(2 * SP);
    chk({7'h00, supply_active}, 8'h00);
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h50);
    ticks(3 * SP);
    chk({7'h00, supply_active}, 8'h01);
    rchk(CSTD_SUPPLY_CTRL_OFS, 8'h58);
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h00);
    // firmware power-off waits four slow ticks
    wr(CSTD_SUPPLY_TIMING_OFS, 8'h42);
    ticks(8);
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h40);
    ticks(5 * SP);
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h00);
    ticks(2 * SP);
    chk({7'h00, supply_active}, 8'h01);
    ticks(4 * SP);
    chk({7'h00, supply_active}, 8'h00);
    // card removal is an emergency: the long power-off delay is skipped
    wr(CSTD_SUPPLY_TIMING_OFS, 8'hf2);
    wr(CSTD_DETECT_CTRL_OFS, 8'h0a);
    wr(CSTD_DETECT_CTRL_OFS, 8'h4a);
    card_in <= 1'b1;
    ticks(10);
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h40);
    ticks(5 * SP);
    chk({7'h00, supply_active}, 8'h01);
    card_in <= 1'b0;
    ticks(12);
    chk({7'h00, supply_active}, 8'h00);
    chk({7'h00, deactivate}, 8'h01);
    wr(CSTD_SUPPLY_CTRL_OFS, 8'h00);
    ticks(4);
    print_verdict();
  end
endmodule

// >>> sim/cstd_slot_model.sv
`timescale 1ns/1ps
module cstd_slot_model
  import cstd_pkg::*;
#(
  parameter real SLOW_HALF_NS = 160.0,
  parameter real KP_HALF_NS   = 64.0
)
(
  // clock
  input  wire logic       core_clk,
  // device side
  input  wire logic       pullup_on_n,
  input  wire logic       pulldown_on,
  input  wire logic [1:0] supply_level_select,
  input  wire logic       supply_active,
  output logic            card_detect_pin,
  output logic            supply_good_flag,
  output logic            slow_clk_32k,
  output logic            keypad_tick_1k,
  // bench control
  input  wire logic       card_in,
  input  wire logic       sw_lvl,
  input  wire logic       supply_fail
);
  logic flt = 1'b0;
  // both slow clocks sped up so a debounce window fits in a short run
  initial slow_clk_32k = 1'b0;
  initial keypad_tick_1k = 1'b0;
  always #(SLOW_HALF_NS) slow_clk_32k = ~slow_clk_32k;
  always #(KP_HALF_NS) keypad_tick_1k = ~keypad_tick_1k;
  // an open pin with no pull wanders instead of keeping its last level
  always @(posedge core_clk) flt <= ~flt;
  assign card_detect_pin = card_in ? sw_lvl :
                           pulldown_on ? 1'b0 : (!pullup_on_n ? 1'b1 : flt);
  // good while a level is commanded or the supply is held on through the power-off delay,
  // and no fault is injected; dropping it on the level write would cut every delay short
  assign supply_good_flag = (|supply_level_select || supply_active) && !supply_fail;
endmodule
